// *** lccp_mon_master.sv ***
`default_nettype none
// Serial link master: makes frames and repeats each monitor byte
module lccp_mon_master #(
  parameter int FRAME = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic send,
  input wire logic [7:0] tx_byte,
  output logic taken,
  output logic frame_sync,
  output logic [7:0] mon_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] fcnt; // Cycle within the frame
  logic [1:0] reps; // Frames the byte was shown
  // Frame counter; sync is high for two cycles
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fcnt <= 8'h00;
    end else begin
      fcnt <= (fcnt == 8'(FRAME - 1)) ? 8'h00 : fcnt + 8'h01;
    end
  end
  assign frame_sync = (fcnt < 8'h02);
  // New byte at frame end; idle shows a pattern that never repeats
  always_ff @(posedge mclk) begin
    taken <= 1'b0;
    if (!rst_n) begin
      reps <= 2'h0;
      mon_byte <= 8'h00;
    end else if (fcnt == 8'(FRAME - 1)) begin
      if (send && reps != 2'h2) begin
        mon_byte <= tx_byte;
        reps <= reps + 2'h1;
      end else begin
        mon_byte <= ~mon_byte;
        reps <= 2'h0;
        taken <= send;
      end
    end
  end
endmodule // lccp_mon_master
`default_nettype wire

// *** lccp_pkg.sv ***
`default_nettype none
// Shared constants and carriers for the line card command port
package lccp_pkg;
  // Latched address codes
  localparam logic [7:0] ADDR_SLOT = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h01;
  localparam logic [7:0] ADDR_STAT = 8'h02;
  localparam logic [7:0] ADDR_RST = 8'hFF;
  // Command selector field positions
  localparam int CMD_TYPE_HI = 5;
  localparam int CMD_TYPE_LO = 4;
  localparam int CMD_SUB_HI = 3;
  localparam int CMD_SUB_LO = 2;
  localparam int CMD_RW_BIT = 6;
  localparam int CMD_BC_BIT = 7;
  // Payload limits
  localparam logic [3:0] MAX_WR_BYTES = 4'h8;
  localparam logic [3:0] MAX_RD_BYTES = 4'hF;
  // Device address byte, value arbitrary
  localparam logic [7:0] DEV_ADDR_DEFAULT = 8'hA5;
  // Slot structure
  localparam int SLOTS_PER_GROUP = 8;
  localparam int SLOT_BITS = 8;
  // Ternary levels
  localparam logic [1:0] TRI_LOW = 2'h0;
  localparam logic [1:0] TRI_MID = 2'h1;
  localparam logic [1:0] TRI_HIGH = 2'h2;

  // Command types
  typedef enum logic [4:0] {
    LCCP_STATUS_OP = 5'h01,
    LCCP_EXTENDED_OP = 5'h02,
    LCCP_TRANSFER_OP = 5'h04,
    LCCP_COEF_OP = 5'h08,
    LCCP_COEF_INIT = 5'h10
  } lccp_cmd_e;

  // Line driver modes
  typedef enum logic [3:0] {
    M_PDN_HIZ = 4'h0, M_PDN_RES = 4'h1, M_RING_HIZ = 4'h2,
    M_ACTIVE_POWERSAVE_A = 4'h3, M_BOOST = 4'h4, M_TIP_HIZ = 4'h5,
    M_ACTIVE_POWERSAVE_B = 4'h6, M_ACTIVE = 4'h7, M_BOTH_HIZ = 4'h8
  } lccp_mode_e;

  // Decoded command byte
  typedef struct packed {
    logic broadcast;
    logic read;
    lccp_cmd_e kind;
    logic [2:0] length;
  } lccp_cmd_s;

  // Byte written into the command FIFO
  typedef struct packed {
    logic first;
    logic [7:0] data;
  } lccp_word_s;
endpackage : lccp_pkg
`default_nettype wire

// *** lccp_top.sv ***
`default_nettype none

// Command byte FIFO with back-pressure
module lccp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage
  logic [AW-1:0] wr_ptr; // Write index
  logic [AW-1:0] rd_ptr; // Read index
  logic [AW:0] count; // Fill level
  logic push;
  logic pop;
  // Full at DEPTH words; the level needs one bit more than the index
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];
  // Storage write
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  // Pointers and level
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : lccp_fifo

// Command port top
module lccp_top
  import lccp_pkg::*;
#(
  parameter logic [7:0] DEV_ADDR = DEV_ADDR_DEFAULT, // Arbitrary value
  parameter int FIFO_DEPTH = 16,
  parameter int GK_CNT_W = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  // Parallel host port
  input wire logic addr_latch,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] host_bus_lines_in,
  output logic [7:0] host_bus_lines_out,
  output logic host_bus_lines_oe,
  // Serial frame and monitor byte from the link deserialiser
  input wire logic frame_sync,
  input wire logic [7:0] mon_byte,
  input wire logic [1:0] ci_down_mode,
  // Command byte output
  output logic [8:0] cmd_data,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic cmd_busy,
  output logic mon_abort,
  output lccp_cmd_e cmd_kind,
  output logic cmd_read,
  output logic cmd_broadcast,
  output logic [3:0] slot_addr,
  // Companion link and line driver
  input wire logic overtemp_sink_current,
  input wire logic [7:0] longitudinal_sense_in,
  input wire logic [7:0] ground_key_limit,
  input wire logic [GK_CNT_W-1:0] ground_key_filter_counter,
  input wire logic [7:0] status_in,
  output logic [1:0] mode_ctrl_first,
  output logic [1:0] mode_ctrl_second,
  output logic upstream_indication_bit3,
  output logic upstream_indication_bit2,
  output logic [7:0] transfer_status_reg0
);
  // Two-stage synchronisers for asynchronous pins
  logic [4:0] s1; // First stage
  logic [4:0] s2; // Second stage
  logic [4:0] s3; // Edge history
  logic [7:0] bus1; // Bus first stage
  logic [7:0] bus2; // Bus second stage
  logic ot1; // Overtemp first stage
  logic ot2; // Overtemp second stage
  logic fs1; // Frame sync stages
  logic fs2;
  logic fs3;

  // Synchronise host strobes, bus, overtemp and frame sync before logic looks at them
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1 <= 5'h0F;
      s2 <= 5'h0F;
      s3 <= 5'h0F;
      bus1 <= 8'h00;
      bus2 <= 8'h00;
      ot1 <= 1'b0;
      ot2 <= 1'b0;
      fs1 <= 1'b0;
      fs2 <= 1'b0;
      fs3 <= 1'b0;
    end else begin
      s1 <= {addr_latch, chip_select_n, read_strobe_n, write_strobe_n,
             1'b1};
      s2 <= s1;
      s3 <= s2;
      bus1 <= host_bus_lines_in;
      bus2 <= bus1;
      ot1 <= overtemp_sink_current;
      ot2 <= ot1;
      fs1 <= frame_sync;
      fs2 <= fs1;
      fs3 <= fs2;
    end
  end

  logic ale_fall;
  logic cs_n;
  logic rd_rise;
  logic wr_rise;
  logic rd_low;
  logic fs_rise;
  assign ale_fall = s3[4] && !s2[4];
  assign cs_n = s2[3];
  assign rd_rise = !s3[2] && s2[2];
  assign wr_rise = !s3[1] && s2[1];
  assign rd_low = !s2[2] && !cs_n;
  assign fs_rise = fs2 && !fs3;

  // Command byte decode, type from bits 5:4 and 3:2
  function automatic lccp_cmd_s decode_cmd(input logic [7:0] b);
    lccp_cmd_s c;
    c.broadcast = b[CMD_BC_BIT];
    c.read = b[CMD_RW_BIT];
    c.length = b[2:0];
    unique case (b[CMD_TYPE_HI:CMD_TYPE_LO])
      2'h1: c.kind = LCCP_STATUS_OP;
      2'h2: c.kind = LCCP_EXTENDED_OP;
      2'h3: c.kind = LCCP_TRANSFER_OP;
      default: c.kind = (b[CMD_SUB_HI:CMD_SUB_LO] == 2'h2) ?
                        LCCP_COEF_INIT : LCCP_COEF_OP;
    endcase
    return c;
  endfunction

  // Payload byte count, clamped to write/read limits
  function automatic logic [3:0] payload_len(input lccp_cmd_s c);
    logic [3:0] n;
    n = (c.length == 3'h7) ? 4'h6 : {1'b0, c.length} + 4'h1;
    if (c.read) begin
      return (n > MAX_RD_BYTES) ? MAX_RD_BYTES : n;
    end
    return (n > MAX_WR_BYTES) ? MAX_WR_BYTES : n;
  endfunction

  // Parallel port sequencer
  typedef enum logic [2:0] {
    P_IDLE = 3'h1,
    P_PAYLOAD = 3'h2,
    P_WAIT_FS = 3'h4
  } lccp_pstate_e;
  lccp_pstate_e pstate;
  logic [7:0] addr; // Latched address
  logic [3:0] remain; // Bytes left in cycle
  logic strobe_end;
  logic fifo_ready;
  logic push_valid;
  lccp_word_s push_word;
  assign strobe_end = !cs_n && (rd_rise || wr_rise);

  // Address latch on ALE fall; bus shared with data
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      addr <= ADDR_RST;
    end else if (ale_fall) begin
      addr <= bus2;
    end
  end

  // Sequencing per latched address code
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pstate <= P_IDLE;
      remain <= 4'h0;
      slot_addr <= 4'h0;
    end else if (strobe_end) begin
      unique case (addr)
        ADDR_SLOT: begin
          slot_addr <= bus2[3:0];
          pstate <= P_WAIT_FS;
        end
        ADDR_RST: pstate <= P_IDLE;
        ADDR_DATA, ADDR_STAT: begin
          if (pstate != P_PAYLOAD) begin
            remain <= payload_len(decode_cmd(bus2));
            pstate <= P_PAYLOAD;
          end else if (remain <= 4'h1) begin
            remain <= 4'h0;
            pstate <= P_WAIT_FS;
          end else begin
            remain <= remain - 4'h1;
          end
        end
        default: ;
      endcase
    end else if (pstate == P_WAIT_FS && fs_rise) begin
      pstate <= P_IDLE;
    end
  end

  // Parallel cycle owns the command path
  assign cmd_busy = (pstate != P_IDLE) || !cs_n;
  assign mon_abort = !cs_n && (!s2[2] || !s2[1]) && pstate == P_IDLE;

  // Monitor channel receiver: double-frame check, address, command
  typedef enum logic [2:0] {
    M_ADDR = 3'h1,
    M_CMD = 3'h2,
    M_DATA = 3'h4
  } lccp_mstate_e;
  lccp_mstate_e mstate;
  logic [7:0] mon_prev; // Last frame byte
  logic mon_seen; // Byte seen once already
  logic [3:0] mon_left; // Payload left
  logic mon_take;
  logic mon_ok;
  lccp_cmd_s mon_cmd; // Monitor byte read as a command byte
  assign mon_cmd = decode_cmd(mon_byte);
  assign mon_take = fs_rise && mon_seen && mon_byte == mon_prev &&
                    !cmd_busy;

  // Frame-to-frame repetition tracking
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mon_prev <= 8'hFF;
      mon_seen <= 1'b0;
    end else if (fs_rise) begin
      mon_prev <= mon_byte;
      mon_seen <= (mon_byte != mon_prev) && !cmd_busy;
    end
  end

  // Monitor command sequence
  always_ff @(posedge mclk) begin
    if (!rst_n || cmd_busy) begin
      mstate <= M_ADDR;
      mon_left <= 4'h0;
    end else if (mon_take) begin
      unique case (mstate)
        M_ADDR: if (mon_byte == DEV_ADDR) mstate <= M_CMD;
        M_CMD: begin
          mon_left <= payload_len(mon_cmd);
          mstate <= mon_cmd.read ? M_ADDR : M_DATA;
        end
        M_DATA: begin
          if (mon_left <= 4'h1) begin
            mstate <= M_ADDR;
          end
          mon_left <= mon_left - 4'h1;
        end
      endcase
    end
  end

  // FIFO feed: parallel data wins over monitor bytes
  assign mon_ok = mon_take && mstate != M_ADDR;
  always_comb begin
    push_word.first = 1'b0;
    push_word.data = bus2;
    push_valid = 1'b0;
    // Slot bytes only steer slot_addr; they never enter the command path
    if (strobe_end && addr == ADDR_DATA && !rd_rise) begin
      push_word.first = (pstate != P_PAYLOAD);
      push_valid = 1'b1;
    end else if (mon_ok) begin
      push_word.first = (mstate == M_CMD);
      push_word.data = mon_byte;
      push_valid = 1'b1;
    end
  end

  lccp_fifo #(.WIDTH($bits(lccp_word_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_data(push_word),
    .in_valid(push_valid),
    .in_ready(fifo_ready),
    .out_data(cmd_data),
    .out_valid(cmd_valid),
    .out_ready(cmd_ready)
  );

  // Last decoded command, held for the consumer
  lccp_cmd_s push_cmd; // Byte being pushed, read as a command
  assign push_cmd = decode_cmd(push_word.data);
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmd_kind <= LCCP_STATUS_OP;
      cmd_read <= 1'b0;
      cmd_broadcast <= 1'b0;
    end else if (push_valid && push_word.first && fifo_ready) begin
      cmd_kind <= push_cmd.kind;
      cmd_read <= push_cmd.read;
      cmd_broadcast <= push_cmd.broadcast;
    end
  end

  // Read data back to host, status on address two
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      host_bus_lines_out <= 8'h00;
    end else begin
      host_bus_lines_out <= (addr == ADDR_STAT) ? status_in
                                                : transfer_status_reg0;
    end
  end
  assign host_bus_lines_oe = rd_low;

  // Ternary mode outputs from requested mode
  lccp_mode_e mode;
  logic pdn;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode <= M_PDN_HIZ;
    end else if (fs_rise) begin
      mode <= lccp_mode_e'({2'h0, ci_down_mode});
    end
  end
  assign pdn = (mode == M_PDN_HIZ) || (mode == M_PDN_RES);

  // Ternary encode of both outputs
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode_ctrl_first <= TRI_LOW;
      mode_ctrl_second <= TRI_LOW;
    end else begin
      unique case (mode)
        M_PDN_HIZ: {mode_ctrl_first, mode_ctrl_second} <= {TRI_LOW, TRI_LOW};
        M_PDN_RES: {mode_ctrl_first, mode_ctrl_second} <= {TRI_LOW, TRI_MID};
        M_RING_HIZ: {mode_ctrl_first, mode_ctrl_second} <= {TRI_LOW, TRI_HIGH};
        M_ACTIVE_POWERSAVE_A: {mode_ctrl_first, mode_ctrl_second} <= {TRI_MID, TRI_LOW};
        M_BOOST: {mode_ctrl_first, mode_ctrl_second} <= {TRI_MID, TRI_MID};
        M_TIP_HIZ: {mode_ctrl_first, mode_ctrl_second} <= {TRI_MID, TRI_HIGH};
        M_ACTIVE_POWERSAVE_B: {mode_ctrl_first, mode_ctrl_second} <= {TRI_HIGH, TRI_LOW};
        M_ACTIVE: {mode_ctrl_first, mode_ctrl_second} <= {TRI_HIGH, TRI_MID};
        default: {mode_ctrl_first, mode_ctrl_second} <= {TRI_HIGH, TRI_HIGH};
      endcase
    end
  end

  // Overtemp and ground-key indication
  logic [GK_CNT_W-1:0] gk_cnt; // Lowpass filter counter
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gk_cnt <= '0;
      upstream_indication_bit3 <= 1'b0;
      upstream_indication_bit2 <= 1'b0;
      transfer_status_reg0 <= 8'h00;
    end else begin
      upstream_indication_bit2 <= ot2 && !pdn;
      transfer_status_reg0 <= {2'h0, ot2 && !pdn, 5'h00};
      if (pdn || longitudinal_sense_in <= ground_key_limit) begin
        gk_cnt <= '0;
      end else if (gk_cnt != ground_key_filter_counter) begin
        gk_cnt <= gk_cnt + GK_CNT_W'(1);
      end
      upstream_indication_bit3 <= !pdn &&
        gk_cnt == ground_key_filter_counter &&
        longitudinal_sense_in > ground_key_limit;
    end
  end
endmodule : lccp_top
`default_nettype wire

// *** lccp_top_properties.sv ***
`default_nettype none
// Port level checks for the command port
module lccp_top_checker
  import lccp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic host_bus_lines_oe,
  input wire logic [8:0] cmd_data,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic cmd_busy,
  input wire logic mon_abort,
  input wire logic [3:0] slot_addr,
  input wire logic [1:0] mode_ctrl_first,
  input wire logic [1:0] mode_ctrl_second,
  input wire logic upstream_indication_bit3,
  input wire logic upstream_indication_bit2,
  input wire logic [7:0] transfer_status_reg0
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire logic pdn; // Line driver in a power down mode
  assign pdn = mode_ctrl_first == TRI_LOW && mode_ctrl_second != TRI_HIGH;
  // Bus idle for a while, and power down held for a while
  sequence s_idle; (chip_select_n && read_strobe_n) [*3]; endsequence
  sequence s_pdn; pdn [*4]; endsequence
  property p_oe_off; s_idle |-> ##1 !host_bus_lines_oe; endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("bus driven idle");
  property p_busy; $rose(cmd_busy) |-> $past(!chip_select_n, 2); endproperty
  a_busy: assert property (p_busy)
    else $error("busy without select");
  property p_abort; $rose(mon_abort) |-> ##[0:2] cmd_busy; endproperty
  a_abort: assert property (p_abort)
    else $error("abort without busy");
  property p_hold;
    cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data);
  endproperty
  a_hold: assert property (p_hold) else $error("head word lost");
  property p_slot;
    $changed(slot_addr) |-> $past(!chip_select_n, 2);
  endproperty
  a_slot: assert property (p_slot) else $error("slot changed idle");
  property p_code;
    mode_ctrl_first != 2'h3 && mode_ctrl_second != 2'h3;
  endproperty
  a_code: assert property (p_code) else $error("bad ternary level");
  property p_gk_pdn; s_pdn |-> !upstream_indication_bit3; endproperty
  a_gk_pdn: assert property (p_gk_pdn)
    else $error("ground key in pdn");
  property p_ot_pdn; s_pdn |-> !upstream_indication_bit2; endproperty
  a_ot_pdn: assert property (p_ot_pdn)
    else $error("overtemp in pdn");
  property p_ot_reg;
    $rose(upstream_indication_bit2) |-> ##[0:2] transfer_status_reg0[5];
  endproperty
  a_ot_reg: assert property (p_ot_reg)
    else $error("status lacks temp");
endmodule // lccp_top_checker

bind lccp_top lccp_top_checker u_chk (
  .mclk, .rst_n, .chip_select_n, .read_strobe_n, .host_bus_lines_oe,
  .cmd_data, .cmd_valid, .cmd_ready, .cmd_busy, .mon_abort, .slot_addr,
  .mode_ctrl_first, .mode_ctrl_second, .upstream_indication_bit3,
  .upstream_indication_bit2, .transfer_status_reg0
);
`default_nettype wire

// *** lccp_top_tb.sv ***
`default_nettype none
`define CHK(nm, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("unexpected %s exp %0h got %0h", nm, e, g); \
  end \
end
// Bench for the command port
module lccp_top_tb_top
  import lccp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  int error_cnt = 0;
  int cmp_count = 0;
  int abort_cnt = 0;
  logic mclk, rst_n, addr_latch, chip_select_n, read_strobe_n;
  logic write_strobe_n, cmd_ready, overtemp_sink_current, send, taken;
  logic frame_sync, host_bus_lines_oe, cmd_valid, cmd_busy, mon_abort;
  logic cmd_read, cmd_broadcast, upstream_indication_bit3;
  logic upstream_indication_bit2;
  logic [7:0] host_bus_lines_in, host_bus_lines_out, mon_byte, tx_byte;
  logic [7:0] longitudinal_sense_in, transfer_status_reg0;
  logic [1:0] ci_down_mode, mode_ctrl_first, mode_ctrl_second;
  logic [8:0] cmd_data;
  logic [3:0] slot_addr;
  lccp_cmd_e cmd_kind;
  lccp_top uut (.mclk, .rst_n, .addr_latch, .chip_select_n, .read_strobe_n,
    .write_strobe_n, .host_bus_lines_in, .host_bus_lines_out,
    .host_bus_lines_oe, .frame_sync, .mon_byte, .ci_down_mode, .cmd_data,
    .cmd_valid, .cmd_ready, .cmd_busy, .mon_abort, .cmd_kind, .cmd_read,
    .cmd_broadcast, .slot_addr, .overtemp_sink_current,
    .longitudinal_sense_in, .ground_key_limit(8'h40),
    .ground_key_filter_counter(8'h04), .status_in(8'h5A),
    .mode_ctrl_first, .mode_ctrl_second, .upstream_indication_bit3,
    .upstream_indication_bit2, .transfer_status_reg0);
  lccp_mon_master #(.FRAME(16)) u_mon (.mclk, .rst_n, .send, .tx_byte,
    .taken, .frame_sync, .mon_byte);
  // Free running clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Count of cycles with a monitor abort shown
  always @(posedge mclk) if (mon_abort === 1'b1) abort_cnt <= abort_cnt + 1;
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Bounded wait: 0 head valid, 1 byte taken, 2 ground key
  task automatic wait_for(input int w, input int lim);
    logic c;
    c = 1'b0;
    for (int n = 0; n < lim && c !== 1'b1; n++) begin
      @(negedge mclk);
      c = (w == 0) ? cmd_valid : (w == 1) ? taken : upstream_indication_bit3;
    end
    if (c !== 1'b1) begin
      error_cnt++;
      $display("unexpected wait %0d exp 1 got 0", w);
      report_and_stop;
    end
  endtask
  // One host cycle: latch address, then read or write strobe
  task automatic par(input logic rd, input logic [7:0] a, input logic [7:0] d);
    host_bus_lines_in = a;
    addr_latch = 1'b1;
    repeat (4) @(negedge mclk);
    addr_latch = 1'b0;
    repeat (4) @(negedge mclk);
    host_bus_lines_in = rd ? ~a : d;
    chip_select_n = 1'b0;
    read_strobe_n = !rd;
    write_strobe_n = rd;
    repeat (5) @(negedge mclk);
    `CHK("oe", rd, host_bus_lines_oe)
    if (rd) `CHK("rdata", 8'h5A, host_bus_lines_out)
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    repeat (6) @(negedge mclk);
    chip_select_n = 1'b1;
    host_bus_lines_in = ~host_bus_lines_in;
    repeat (4) @(negedge mclk);
  endtask
  task automatic pop(input logic [8:0] e);
    wait_for(0, 100);
    `CHK("cmd_data", e, cmd_data)
    cmd_ready = 1'b1;
    @(negedge mclk);
    cmd_ready = 1'b0;
  endtask
  task automatic mon_send(input logic [7:0] b);
    tx_byte = b;
    send = 1'b1;
    wait_for(1, 200);
    send = 1'b0;
    @(negedge mclk);
  endtask
  task automatic t_cmds;
    logic [7:0] op [5] = '{8'h50, 8'h60, 8'h70, 8'h44, 8'h48};
    lccp_cmd_e k [5] = '{LCCP_STATUS_OP, LCCP_EXTENDED_OP,
      LCCP_TRANSFER_OP, LCCP_COEF_OP, LCCP_COEF_INIT};
    `CHK("mode1", TRI_LOW, mode_ctrl_first)
    `CHK("valid", 1'b0, cmd_valid)
    for (int i = 0; i < 5; i++) begin
      par(1'b0, ADDR_DATA, op[i]);
      pop({1'b1, op[i]});
      `CHK("kind", k[i], cmd_kind)
      `CHK("read", 1'b1, cmd_read)
      par(1'b0, ADDR_RST, 8'h00);
    end
    par(1'b1, ADDR_STAT, 8'h00);
    par(1'b0, ADDR_RST, 8'h00);
    $display("test commands done");
  endtask
  task automatic t_write;
    par(1'b0, ADDR_DATA, 8'h90);
    par(1'b0, ADDR_DATA, 8'h3C);
    pop(9'h190);
    `CHK("bcast", 1'b1, cmd_broadcast)
    `CHK("read", 1'b0, cmd_read)
    pop(9'h03C);
    par(1'b0, ADDR_DATA, 8'h50);
    pop(9'h150);
    par(1'b0, ADDR_RST, 8'h00);
    par(1'b0, ADDR_SLOT, 8'h0B);
    `CHK("slot", 4'hB, slot_addr)
    par(1'b0, 8'h03, 8'h05);
    `CHK("slot", 4'hB, slot_addr)
    `CHK("valid", 1'b0, cmd_valid)
    $display("test write done");
  endtask
  task automatic t_fifo;
    int n;
    for (int i = 0; i < 21; i++) begin
      par(1'b0, ADDR_DATA, (i % 7 == 0) ? 8'h17 : 8'(i));
    end
    pop(9'h117);
    n = 1;
    while (cmd_valid === 1'b1 && n < 40) begin
      cmd_ready = 1'b1;
      @(negedge mclk);
      n++;
    end
    cmd_ready = 1'b0;
    `CHK("depth", 16, n)
    par(1'b0, ADDR_RST, 8'h00);
    $display("test fifo done");
  endtask
  task automatic t_mon;
    int a0;
    mon_send(DEV_ADDR_DEFAULT);
    mon_send(8'h10);
    mon_send(8'h3C);
    pop(9'h110);
    pop(9'h03C);
    a0 = abort_cnt;
    mon_send(DEV_ADDR_DEFAULT);
    tx_byte = 8'h10;
    send = 1'b1;
    par(1'b0, ADDR_DATA, 8'h50);
    send = 1'b0;
    `CHK("abort", 1'b1, abort_cnt > a0)
    `CHK("busy", 1'b1, cmd_busy)
    pop(9'h150);
    par(1'b0, ADDR_RST, 8'h00);
    repeat (64) @(negedge mclk);
    `CHK("valid", 1'b0, cmd_valid)
    `CHK("busy", 1'b0, cmd_busy)
    mon_send(8'h10);
    mon_send(8'h3C);
    `CHK("valid", 1'b0, cmd_valid)
    mon_send(DEV_ADDR_DEFAULT);
    mon_send(8'h10);
    mon_send(8'h3C);
    pop(9'h110);
    pop(9'h03C);
    $display("test monitor done");
  endtask
  task automatic t_mode;
    logic [1:0] f [4] = '{TRI_LOW, TRI_LOW, TRI_LOW, TRI_MID};
    logic [1:0] s [4] = '{TRI_LOW, TRI_MID, TRI_HIGH, TRI_LOW};
    overtemp_sink_current = 1'b1;
    for (int i = 0; i < 4; i++) begin
      ci_down_mode = 2'(i);
      par(1'b0, ADDR_SLOT, 8'h01);
      repeat (24) @(negedge mclk);
      `CHK("mode1", f[i], mode_ctrl_first)
      `CHK("mode2", s[i], mode_ctrl_second)
      `CHK("ot", i > 1, upstream_indication_bit2)
      `CHK("ot_reg", i > 1, transfer_status_reg0[5])
    end
    longitudinal_sense_in = 8'hF0;
    wait_for(2, 3000);
    `CHK("gk", 1'b1, upstream_indication_bit3)
    ci_down_mode = 2'h0;
    repeat (48) @(negedge mclk);
    `CHK("gk", 1'b0, upstream_indication_bit3)
    $display("test mode done");
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    addr_latch = 1'b0;
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    host_bus_lines_in = 8'h00;
    cmd_ready = 1'b0;
    overtemp_sink_current = 1'b0;
    longitudinal_sense_in = 8'h00;
    ci_down_mode = 2'h0;
    send = 1'b0;
    tx_byte = 8'h00;
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    t_cmds;
    t_write;
    t_fifo;
    t_mon;
    t_mode;
    report_and_stop;
  end
endmodule // lccp_top_tb_top
`default_nettype wire
